/* File: hw/pmbg_bank.sv */
// Pin mode register and core buck control registers with pin driven enable and voltage select
`timescale 1ns/10ps
`include "pmbg_map.svh"
// Behaviour
// - Mode bit one enables input debouncing
// - Plain output drives mode bit level
// - Blink pins: 0 active high, 1 low
// - Pin 13 feedback polarity from bit 5
// - Pin 12 fault output polarity bit 4
// - Pins 10, 8 bits set debounce/level
// - Select field: sequencer, pin1, pin2, pin13
// - Core2 voltage A on activate, B release
// - Core2 enable follows selected pin edges
// - Core2 sequencer target and direct enable
// - Core2 register ignored in dual-phase mode
// - Bit 7 holds switch sequencer target
// - Core1 voltage A on activate, B release
// - Core1 sequencer target and direct enable
// - Core1 enable follows selected pin edges
module pmbg_bank #(
	parameter int DEB_CYCLES = `PMBG_DEB_CYCLES
) (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic [7:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data, registered
	input wire logic dual_phase_i, // Core bucks in dual-phase mode
	input wire logic seq_apply_i, // Sequencer drives targets now
	input wire logic pin1_i, // Pin 1 level
	input wire logic pin2_i, // Pin 2 level
	input wire logic pin13_i, // Pin 13 level when input
	input wire logic [15:8] pin_is_output_i, // Pin direction, 1 output
	input wire logic [15:8] pin_special_i, // Pin in its special function
	input wire logic [15:8] pin_in_i, // Raw levels of pins 8 to 15
	input wire logic blink_i, // Blink pattern, 1 lit
	input wire logic power_good_feedback_i, // Feedback state
	input wire logic supply_fault_i, // Supply fault or monitor state
	output logic [15:8] pin_out_o, // Output levels of pins 8 to 15
	output logic [15:8] pin_deb_o, // Debounced levels of pins 8 to 15
	output logic core2_buck_on_o, // Core2 buck enable
	output logic core2_volt_b_o, // Core2 target: 0 A, 1 B
	output logic core1_buck_on_o, // Core1 buck enable
	output logic core1_volt_b_o, // Core1 target: 0 A, 1 B
	output logic core_switch_on_o // Core power switch closed
);
	// ==============================
	// Registers
	logic [7:0] mode_q;
	logic [7:0] core2_q;
	logic [7:0] core1_q;
	logic [7:0] pin_cfg_q; // Input polarity of pins 1, 2, 13 in bits 0..2
	logic core2_volt_b_q;
	logic core1_volt_b_q;
	logic [2:0] act;
	logic [2:0] act_d1_q;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [2:0] deb_sel;

	function automatic logic [1:0] pin_edge(input logic [1:0] sel, input logic [2:0] r, input logic [2:0] f);
		logic [1:0] res;
		res = 2'b00;
		unique case (pmbg_pkg::pmbg_sel_e'(sel))
			pmbg_pkg::PMBG_SEL_SEQ: res = 2'b00;
			pmbg_pkg::PMBG_SEL_PIN1: res = {r[0], f[0]};
			pmbg_pkg::PMBG_SEL_PIN2: res = {r[1], f[1]};
			pmbg_pkg::PMBG_SEL_PIN13: res = {r[2], f[2]};
		endcase
		return res;
	endfunction

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= `PMBG_RST_MODE;
			core1_q <= `PMBG_RST_CTRL;
			pin_cfg_q <= `PMBG_RST_PIN_CFG;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				`PMBG_OFS_PIN_MODE_HIGH: mode_q <= reg_wdata_i;
				`PMBG_OFS_CORE1_CTRL: core1_q <= reg_wdata_i;
				`PMBG_OFS_PIN_CFG: pin_cfg_q <= reg_wdata_i & 8'h07;
				default: ;
			endcase
		end
	end

	// Core2 control held still while the bucks are paralleled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core2_q <= `PMBG_RST_CTRL;
		end else if (reg_wr_i && reg_addr_i == `PMBG_OFS_CORE2_CTRL && !dual_phase_i) begin
			core2_q <= reg_wdata_i & 8'h6f;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`PMBG_OFS_PIN_MODE_HIGH: reg_rdata_o <= mode_q;
				`PMBG_OFS_CORE2_CTRL: reg_rdata_o <= core2_q;
				`PMBG_OFS_CORE1_CTRL: reg_rdata_o <= core1_q;
				`PMBG_OFS_PIN_CFG: reg_rdata_o <= pin_cfg_q;
				`PMBG_OFS_STATUS: reg_rdata_o <= {2'b00, core_switch_on_o, core1_volt_b_q, core1_buck_on_o,
					core2_volt_b_q, core2_buck_on_o, dual_phase_i};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ==============================
	// Controlling pins; pin 13 debounce follows its mode bit, pins 1 and 2 debounce always
	assign deb_sel = {mode_q[`PMBG_BIT_PIN13], 2'b11};
	for (genvar g = 0; g < 3; g++) begin : g_ctl
		pmbg_pin_filter #(.DEB_CYCLES(DEB_CYCLES)) u_filt (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.pin_i(g == 0 ? pin1_i : (g == 1 ? pin2_i : pin13_i)),
			.deb_en_i(deb_sel[g]),
			.active_high_i(pin_cfg_q[g]),
			.active_o(act[g])
		);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			act_d1_q <= 3'b000;
		end else begin
			act_d1_q <= act;
		end
	end
	assign rise = act & ~act_d1_q;
	assign fall = ~act & act_d1_q;

	// ==============================
	// Pins 8 to 15 inputs, debounce per mode bit; polarity is left to the consumer
	for (genvar p = 8; p < 16; p++) begin : g_gp
		pmbg_pin_filter #(.DEB_CYCLES(DEB_CYCLES)) u_filt (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.pin_i(pin_in_i[p]),
			.deb_en_i(mode_q[p-8]),
			.active_high_i(1'b1),
			.active_o(pin_deb_o[p])
		);
	end

	// ==============================
	// Output levels
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_out_o <= 8'h00;
		end else begin
			for (int i = 8; i < 16; i++) begin
				pin_out_o[i] <= pin_is_output_i[i] & mode_q[i-8];
			end
			if (pin_special_i[11]) pin_out_o[11] <= blink_i ^ mode_q[`PMBG_BIT_PIN11];
			if (pin_special_i[14]) pin_out_o[14] <= blink_i ^ mode_q[`PMBG_BIT_PIN14];
			if (pin_special_i[15]) pin_out_o[15] <= blink_i ^ mode_q[`PMBG_BIT_PIN15];
			if (pin_special_i[13]) pin_out_o[13] <= power_good_feedback_i ~^ mode_q[`PMBG_BIT_PIN13];
			if (pin_special_i[12]) pin_out_o[12] <= supply_fault_i ~^ mode_q[`PMBG_BIT_PIN12];
			if (pin_special_i[9]) pin_out_o[9] <= seq_apply_i ~^ mode_q[`PMBG_BIT_PIN9];
		end
	end

	// ==============================
	// Core2 enable and voltage; a pin edge wins over a direct write in the same cycle
	logic [1:0] c2_en_ev;
	logic [1:0] c2_v_ev;
	logic [1:0] c1_en_ev;
	logic [1:0] c1_v_ev;
	assign c2_en_ev = pin_edge(core2_q[2:1], rise, fall) & {2{!dual_phase_i}};
	assign c2_v_ev = pin_edge(core2_q[6:5], rise, fall) & {2{!dual_phase_i}};
	assign c1_en_ev = pin_edge(core1_q[2:1], rise, fall);
	assign c1_v_ev = pin_edge(core1_q[6:5], rise, fall);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core2_buck_on_o <= 1'b0;
			core2_volt_b_o <= 1'b0;
			core2_volt_b_q <= 1'b0;
		end else begin
			if (c2_en_ev[1]) core2_buck_on_o <= 1'b1;
			else if (c2_en_ev[0]) core2_buck_on_o <= 1'b0;
			else if (seq_apply_i && core2_q[2:1] == 2'b00 && !dual_phase_i)
				core2_buck_on_o <= core2_q[`PMBG_BIT_SEQ_TARGET];
			else if (!dual_phase_i && core2_q[2:1] == 2'b00) core2_buck_on_o <= core2_q[`PMBG_BIT_BUCK_ON];
			if (c2_v_ev[1]) core2_volt_b_q <= 1'b0;
			else if (c2_v_ev[0]) core2_volt_b_q <= 1'b1;
			core2_volt_b_o <= c2_v_ev[1] ? 1'b0 : (c2_v_ev[0] ? 1'b1 : core2_volt_b_q);
		end
	end

	// ==============================
	// Core1 enable, voltage and power switch
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core1_buck_on_o <= 1'b0;
			core1_volt_b_o <= 1'b0;
			core1_volt_b_q <= 1'b0;
			core_switch_on_o <= 1'b0;
		end else begin
			if (c1_en_ev[1]) core1_buck_on_o <= 1'b1;
			else if (c1_en_ev[0]) core1_buck_on_o <= 1'b0;
			else if (seq_apply_i && core1_q[2:1] == 2'b00)
				core1_buck_on_o <= core1_q[`PMBG_BIT_SEQ_TARGET];
			else if (core1_q[2:1] == 2'b00) core1_buck_on_o <= core1_q[`PMBG_BIT_BUCK_ON];
			if (c1_v_ev[1]) core1_volt_b_q <= 1'b0;
			else if (c1_v_ev[0]) core1_volt_b_q <= 1'b1;
			core1_volt_b_o <= c1_v_ev[1] ? 1'b0 : (c1_v_ev[0] ? 1'b1 : core1_volt_b_q);
			if (seq_apply_i) core_switch_on_o <= core1_q[`PMBG_BIT_SWITCH_SEQ];
			else core_switch_on_o <= core1_q[`PMBG_BIT_SWITCH_ON];
		end
	end
endmodule // pmbg_bank

/* File: hw/pmbg_map.svh */
// Register offsets, field positions, reset values and timing counts for the pin mode and buck control bank
`ifndef PMBG_MAP_SVH
`define PMBG_MAP_SVH
`define PMBG_OFS_PIN_MODE_HIGH 8'h1e
`define PMBG_OFS_RESERVED 8'h1f
`define PMBG_OFS_CORE2_CTRL 8'h20
`define PMBG_OFS_CORE1_CTRL 8'h21
`define PMBG_OFS_PIN_CFG 8'h30
`define PMBG_OFS_STATUS 8'h31
`define PMBG_BIT_SEQ_TARGET 3
`define PMBG_BIT_BUCK_ON 0
`define PMBG_BIT_SWITCH_ON 4
`define PMBG_BIT_SWITCH_SEQ 7
`define PMBG_SEL_EN_LSB 1
`define PMBG_SEL_VOLT_LSB 5
`define PMBG_BIT_PIN8 0
`define PMBG_BIT_PIN9 1
`define PMBG_BIT_PIN10 2
`define PMBG_BIT_PIN11 3
`define PMBG_BIT_PIN12 4
`define PMBG_BIT_PIN13 5
`define PMBG_BIT_PIN14 6
`define PMBG_BIT_PIN15 7
`define PMBG_RST_MODE 8'h00
`define PMBG_RST_CTRL 8'h00
`define PMBG_RST_PIN_CFG 8'h00
`define PMBG_DEB_TIME_US 10
`define PMBG_CLK_MHZ 100
`define PMBG_DEB_CYCLES (`PMBG_DEB_TIME_US * `PMBG_CLK_MHZ)
`endif

/* File: hw/pmbg_pin_filter.sv */
// Synchroniser, optional debouncer and polarity decode for one controlling pin
`timescale 1ns/10ps
module pmbg_pin_filter #(
	parameter int DEB_CYCLES = 1000
) (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic pin_i, // Raw pin level
	input wire logic deb_en_i, // Debouncing enabled
	input wire logic active_high_i, // Pin polarity
	output logic active_o // Pin is in its active state
);
	// ==============================
	// Synchroniser
	logic sync1_q;
	logic sync2_q;
	logic stable_q;
	logic [$clog2(DEB_CYCLES+1)-1:0] cnt_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end
	// ==============================
	// Debounce: a new level must hold for the whole window before it is taken
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stable_q <= 1'b0;
			cnt_q <= '0;
		end else if (!deb_en_i || sync2_q == stable_q) begin
			stable_q <= sync2_q;
			cnt_q <= '0;
		end else if (cnt_q == ($bits(cnt_q))'(DEB_CYCLES - 1)) begin
			stable_q <= sync2_q;
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	// ==============================
	// Polarity
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= stable_q ~^ active_high_i;
		end
	end
endmodule // pmbg_pin_filter

/* File: hw/pmbg_pkg.sv */
// Types shared by the pin mode and buck control bank
package pmbg_pkg;
	typedef enum logic [1:0] {
		PMBG_SEL_SEQ,
		PMBG_SEL_PIN1,
		PMBG_SEL_PIN2,
		PMBG_SEL_PIN13
	} pmbg_sel_e;
	typedef logic [7:0] pmbg_byte_t;
endpackage

/* File: tb/pin_mode_and_buck_gpio_control_tb_top.sv */
// Testbench of the pin mode and buck control bank
`timescale 1ns/10ps
module pin_mode_and_buck_gpio_control_tb_top;
	localparam int DEB = 4;
	logic clk_i = 1'b0, rst_n_i = 1'b0, dual = 1'b0, seq = 1'b0, blink = 1'b0, fb = 1'b0, fault = 1'b0;
	logic [15:8] is_out = 8'h00, special = 8'h00, pin_in = 8'h00, pin_out, pin_deb;
	logic [7:0] addr, wdata, rdata, v;
	logic wr, rd, c2_on, c2_b, c1_on, c1_b, sw_on, seen;
	logic [2:0] pins;
	int mismatches = 0;
	int tests_run = 0;
	pmbg_host i_pmbg_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata),
		.pins_o(pins));
	pmbg_bank #(.DEB_CYCLES(DEB)) i_pmbg_bank (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .dual_phase_i(dual),
		.seq_apply_i(seq), .pin1_i(pins[0]), .pin2_i(pins[1]), .pin13_i(pins[2]), .pin_is_output_i(is_out),
		.pin_special_i(special), .pin_in_i(pin_in), .blink_i(blink), .power_good_feedback_i(fb),
		.supply_fault_i(fault), .pin_out_o(pin_out), .pin_deb_o(pin_deb), .core2_buck_on_o(c2_on),
		.core2_volt_b_o(c2_b), .core1_buck_on_o(c1_on), .core1_volt_b_o(c1_b), .core_switch_on_o(sw_on));
	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ====
	// Clock, watchdog and test sequence
	initial forever #5 clk_i = ~clk_i;
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
	initial begin
		tick(8);
		rst_n_i = 1'b1;
		i_pmbg_host.wr(8'h1f, 8'hff);
		for (int a = 8'h1e; a <= 8'h21; a++) begin
			i_pmbg_host.rd(8'(a), v);
			check("reset value", v, 8'h00);
		end
		is_out = 8'hff;
		i_pmbg_host.wr(8'h1e, 8'ha5);
		i_pmbg_host.rd(8'h1e, v);
		check("mode readback", v, 8'ha5);
		tick(3);
		check("plain levels", pin_out, 8'ha5);
		// Pin 9 joins as a sequencer output while the sequencer is idle
		special = 8'hfa;
		blink = 1'b1;
		fb = 1'b1;
		fault = 1'b1;
		tick(3);
		check("special levels", pin_out, 8'h6f);
		i_pmbg_host.wr(8'h1e, 8'h5a);
		tick(3);
		check("special levels", pin_out, 8'h90);
		is_out = 8'h00;
		special = 8'h00;
		for (int m = 0; m < 2; m++) begin
			i_pmbg_host.wr(8'h1e, 8'(m));
			tick(DEB + 8);
			seen = 1'b0;
			pin_in[8] = 1'b1;
			tick(2);
			pin_in[8] = 1'b0;
			repeat (DEB + 8) begin
				tick(1);
				seen = seen | pin_deb[8];
			end
			check("short glitch", {7'h00, seen}, 8'(1 - m));
		end
		i_pmbg_host.wr(8'h30, 8'h07);
		for (int s = 1; s < 4; s++) begin
			i_pmbg_host.wr(8'h21, {1'b0, 2'(s), 2'b00, 2'(s), 1'b0});
			i_pmbg_host.wr(8'h20, {1'b0, 2'(s), 2'b00, 2'(s), 1'b0});
			i_pmbg_host.drive(3'(1 << (s - 1)));
			tick(DEB + 8);
			check("pin active", {4'h0, c2_on, c2_b, c1_on, c1_b}, 8'h0a);
			i_pmbg_host.drive(3'b000);
			tick(DEB + 8);
			check("pin passive", {4'h0, c2_on, c2_b, c1_on, c1_b}, 8'h05);
		end
		i_pmbg_host.wr(8'h21, 8'h22);
		i_pmbg_host.wr(8'h30, 8'h00);
		tick(DEB + 8);
		check("low active pin", {6'h00, c1_on, c1_b}, 8'h02);
		i_pmbg_host.wr(8'h21, 8'h91);
		i_pmbg_host.wr(8'h20, 8'h01);
		tick(2);
		check("direct enables", {5'h00, c2_on, c1_on, sw_on}, 8'h07);
		// Core2 went to target A when pin 13 turned active under low polarity
		i_pmbg_host.rd(8'h31, v);
		check("status", v, 8'h2a);
		seq = 1'b1;
		tick(3);
		check("sequencer targets", {5'h00, c2_on, c1_on, sw_on}, 8'h01);
		// Let the direct enable return before freezing core2
		seq = 1'b0;
		tick(2);
		dual = 1'b1;
		i_pmbg_host.wr(8'h20, 8'h00);
		i_pmbg_host.rd(8'h20, v);
		check("core2 in dual phase", v, 8'h01);
		check("core2 enable held", {7'h00, c2_on}, 8'h01);
		summarize();
	end
endmodule // pin_mode_and_buck_gpio_control_tb_top

/* File: tb/pmbg_host.sv */
// Host model driving register strobes and the controlling pins
`timescale 1ns/10ps
module pmbg_host (
	input wire logic clk_i, // System clock
	output logic [7:0] addr_o = 8'h00, // Register address
	output logic [7:0] wdata_o = 8'h00, // Write data
	output logic wr_o = 1'b0, // Write strobe
	output logic rd_o = 1'b0, // Read strobe
	input wire logic [7:0] rdata_i, // Read data
	output logic [2:0] pins_o = 3'b000 // Pins 13, 2, 1
);
	// ====
	// Requests launch just after an edge and hold through the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i) #1;
		rd_o = 1'b0;
		d = rdata_i;
	endtask
	task automatic drive(input logic [2:0] p);
		@(posedge clk_i) #1;
		pins_o = p;
	endtask
endmodule // pmbg_host

/* File: tb/pmbg_monitor.sv */
// Checker of the pin mode and buck control bank
`timescale 1ns/10ps
module pmbg_monitor (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	input wire logic dual_phase_i, // Dual-phase mode
	input wire logic seq_apply_i, // Sequencer applying targets
	input wire logic [7:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic [7:0] reg_rdata_o, // Read data
	input wire logic blink_i, // Blink pattern
	input wire logic power_good_feedback_i, // Feedback state
	input wire logic supply_fault_i, // Fault or monitor state
	input wire logic [15:8] pin_is_output_i, // Pin direction
	input wire logic [15:8] pin_special_i, // Pin special function
	input wire logic [15:8] pin_out_o, // Output levels
	input wire logic core2_buck_on_o, // Core2 buck enable
	input wire logic core2_volt_b_o, // Core2 target select
	input wire logic core1_buck_on_o, // Core1 buck enable
	input wire logic core_switch_on_o // Core power switch
);
	// ====
	// Shadows of the written mode and core1 control registers
	logic [7:0] mode_q, c1_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			mode_q <= 8'h00;
		else if (reg_wr_i && reg_addr_i == 8'h1e)
			mode_q <= reg_wdata_i;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			c1_q <= 8'h00;
		else if (reg_wr_i && reg_addr_i == 8'h21)
			c1_q <= reg_wdata_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ====
	// Three steady cycles cover the output register's one-edge latency
	sequence s_pin(n, sp, src);
		(pin_is_output_i[n] && pin_special_i[n] == sp && $stable(mode_q) && $stable(src))[*3];
	endsequence
	sequence s_c1(sq);
		(seq_apply_i == sq && $stable(c1_q) && c1_q[2:1] == 2'b00)[*2];
	endsequence
	property p_plain; s_pin(9, 1'b0, 1'b0) |-> pin_out_o[9] == mode_q[1]; endproperty
	property p_blink; s_pin(11, 1'b1, blink_i) |-> pin_out_o[11] == (blink_i ^ mode_q[3]); endproperty
	property p_fb; s_pin(13, 1'b1, power_good_feedback_i) |-> pin_out_o[13] == (power_good_feedback_i ~^ mode_q[5]);
	endproperty
	property p_fault; s_pin(12, 1'b1, supply_fault_i) |-> pin_out_o[12] == (supply_fault_i ~^ mode_q[4]); endproperty
	property p_c1_dir; s_c1(1'b0) |-> core1_buck_on_o == c1_q[0] && core_switch_on_o == c1_q[4]; endproperty
	property p_c1_seq; s_c1(1'b1) |-> core1_buck_on_o == c1_q[3] && core_switch_on_o == c1_q[7]; endproperty
	property p_c2_frozen; dual_phase_i[*2] |=> $stable(core2_buck_on_o) && $stable(core2_volt_b_o); endproperty
	property p_rsvd; reg_rd_i && reg_addr_i == 8'h1f |=> reg_rdata_o == 8'h00; endproperty
	a_plain: assert property (p_plain) else $error("plain output level wrong");
	a_blink: assert property (p_blink) else $error("blink polarity wrong");
	a_fb: assert property (p_fb) else $error("feedback polarity wrong");
	a_fault: assert property (p_fault) else $error("fault polarity wrong");
	a_c1_dir: assert property (p_c1_dir) else $error("core1 direct enable wrong");
	a_c1_seq: assert property (p_c1_seq) else $error("sequencer target wrong");
	a_c2_frozen: assert property (p_c2_frozen) else $error("core2 moved in dual phase");
	a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
endmodule // pmbg_monitor
bind pmbg_bank pmbg_monitor i_pmbg_monitor (.*);
